/* File: core/rsws_pkg.sv */
// Package: register map, field positions and timing of the sequencer
`default_nettype none
package rsws_pkg;
  // Clock and time base
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TICK_NS       = 31250;
  localparam int unsigned TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned RST_HOLD_NS   = 100;
  localparam int unsigned RST_HOLD_CYC  =
    (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ACT_TIMEOUT_MS  = 4000;
  localparam int unsigned ACT_TIMEOUT_CYC =
    ACT_TIMEOUT_MS * (1000000 / CLK_PERIOD_NS);
  localparam int unsigned PON_DEFAULT_US  = 343750;
  localparam logic [15:0] PON_DEFAULT_TICKS =
    16'(PON_DEFAULT_US * 1000 / TICK_NS);

  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_STATUS   = 8'h00;
  localparam logic [7:0] OFS_CONTROL  = 8'h04;
  localparam logic [7:0] OFS_WAIT     = 8'h08;
  localparam logic [7:0] OFS_WDCLEAR  = 8'h0c;
  localparam logic [7:0] OFS_WDCONFIG = 8'h10;

  // Status register fields
  localparam int unsigned ST_DOMAIN   = 0;
  localparam int unsigned ST_SWITCH   = 1;
  localparam int unsigned ST_WATCHDOG = 2;
  localparam int unsigned ST_TIMEOUT  = 3;
  localparam int unsigned ST_BATTERY  = 4;
  localparam int unsigned ST_PWRSWINT = 5;
  localparam int unsigned ST_RETAIN   = 6;
  localparam int unsigned ST_SDRAM    = 7;
  localparam logic [7:0]  ST_FLAGS    = 8'h3f;
  localparam logic [7:0]  ST_RESET    = 8'h01;

  // Control, clear and config fields
  localparam int unsigned CT_EDO      = 0;
  localparam int unsigned CT_ACTCLR   = 2;
  localparam int unsigned WD_CLEAR    = 0;
  localparam int unsigned WD_ENABLE   = 0;
  localparam int unsigned WD_PER_LSB  = 16;
  localparam logic [15:0] WD_PER_RESET = 16'h0400;

  // Sequencer states, one-hot
  typedef enum logic [6:0] {
    ST_COLD   = 7'h01,
    ST_RUN    = 7'h02,
    ST_RSW    = 7'h04,
    ST_HIB    = 7'h08,
    ST_SHUT   = 7'h10,
    ST_PON    = 7'h20,
    ST_CHECK  = 7'h40
  } rsws_state_e;
endpackage
`default_nettype wire

/* File: core/rsws_sequencer.sv */
// Reset, shutdown and wake sequencer of the power manager
//
// Overview of operation
// - Domain reset resets everything, sets its flag
// - Switch resets core; peripherals unless retention set
// - Retention set: switch resets only the core
// - Switch event sets switch cause flag
// - Watchdog expiry resets peripherals, core, sets flag
// - Switch with EDO issues CBR self-refresh
// - SDRAM bit set: memory controller not reset by switch
// - SDRAM and retention clear: memory controller reset at once
// - Activation timeout resets all but manager, flags
// - Hibernate without pending irq stops clock, resets
// - Battery inhibit low at activation aborts, shuts down
// - Twenty wake sources accepted
// - Power-on period programmable, default 343.75 ms
// - Power switch raises power-on indicator
// - Card busy raises power-on indicator
// - Sample battery, then drop power-on indicator
// - Battery high: release resets, cold-reset core
// - Battery low: set flag, shut down again
// - Power switch wake never sets switch interrupt
// - Main power drops after clocks stop, pipeline halts
//
// Chosen here: the address map and the strobed register port.
`default_nettype none
module rsws_sequencer #(
  parameter int unsigned ACT_TIMEOUT = rsws_pkg::ACT_TIMEOUT_CYC
) (
  // Clock and always-on domain reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdata,
  // Core handshakes
  input  wire logic        hibernateReq,
  input  wire logic        irqPending,
  input  wire logic        pipelineHalted,
  // Wake and power inputs
  input  wire logic        resetSwitchN,
  input  wire logic        powerSwitch,
  input  wire logic [15:0] gpioWake,
  input  wire logic        carrierDetectN,
  input  wire logic        cardBusyWakeN,
  input  wire logic        alarmWake,
  input  wire logic        batteryInhibit,
  // Reset and power outputs
  output logic             coreResetN,
  output logic             periphResetN,
  output logic             gioResetN,
  output logic             rtcResetN,
  output logic             memCtlResetN,
  output logic             coreClockStop,
  output logic             mainPowerEnable,
  output logic             powerOnIndicator,
  output logic             dramCasN,
  output logic             dramRasN
);

  typedef struct packed {
    rsws_pkg::rsws_state_e state;
    logic [31:0] cnt;
    logic [11:0] tick;
    logic [31:0] actTmr;
    logic [15:0] wdCnt;
    logic [7:0]  status;
    logic        edoMode;
    logic        wdEn;
    logic [15:0] wdPeriod;
    logic [15:0] waitTicks;
    logic        swPrev;
    logic        pwrPrev;
    logic        scopePeri;
    logic        scopeGio;
    logic        scopeMem;
    logic        coreRstN;
    logic        periRstN;
    logic        gioRstN;
    logic        rtcRstN;
    logic        memRstN;
    logic        clkStop;
    logic        mainPwr;
    logic        ponInd;
    logic        casN;
    logic        rasN;
    logic [31:0] rdata;
  } rsws_regs_s;

  rsws_regs_s r_reg;
  rsws_regs_s r_next;

  // Decoded events
  logic tickEv;
  logic swEvent;
  logic wake;
  logic wdExpire;
  logic actExpire;
  logic wrStatus;
  logic wrControl;
  logic wrWait;
  logic wrWdClr;
  logic wrWdCfg;
  logic [7:0] setFlags;
  logic [7:0] clrFlags;

  // Register write decode
  always_comb begin
    wrStatus  = 1'b0;
    wrControl = 1'b0;
    wrWait    = 1'b0;
    wrWdClr   = 1'b0;
    wrWdCfg   = 1'b0;
    if (regWr && regAddr == rsws_pkg::OFS_STATUS) begin
      wrStatus = 1'b1;
    end else if (regWr && regAddr == rsws_pkg::OFS_CONTROL) begin
      wrControl = 1'b1;
    end else if (regWr && regAddr == rsws_pkg::OFS_WAIT) begin
      wrWait = 1'b1;
    end else if (regWr && regAddr == rsws_pkg::OFS_WDCLEAR) begin
      wrWdClr = 1'b1;
    end else if (regWr && regAddr == rsws_pkg::OFS_WDCONFIG) begin
      wrWdCfg = 1'b1;
    end
  end

  // Event detection; inputs are already in this clock domain
  assign tickEv  = (r_reg.tick == 12'(rsws_pkg::TICK_CYC - 1));
  assign swEvent = r_reg.swPrev && !resetSwitchN;
  // Any of the twenty wake sources
  assign wake    = powerSwitch || (|gpioWake) || !carrierDetectN ||
                   !cardBusyWakeN || alarmWake;
  assign wdExpire  = r_reg.wdEn && (r_reg.wdCnt >= r_reg.wdPeriod);
  assign actExpire = (r_reg.actTmr >= ACT_TIMEOUT - 1);

  // Sequencer, timers and registers
  always_comb begin
    r_next = r_reg;
    setFlags = 8'h00;
    clrFlags = 8'h00;
    r_next.swPrev  = resetSwitchN;
    r_next.pwrPrev = powerSwitch;
    r_next.rtcRstN = 1'b1;
    r_next.tick = tickEv ? 12'h000 : r_reg.tick + 12'h001;
    r_next.cnt = r_reg.cnt + 32'h1;

    // Timers run only while the core runs
    if (r_reg.state == rsws_pkg::ST_RUN) begin
      r_next.actTmr = r_reg.actTmr + 32'h1;
      if (tickEv && r_reg.wdEn) begin
        r_next.wdCnt = r_reg.wdCnt + 16'h0001;
      end
    end
    if (wrControl && regWdata[rsws_pkg::CT_ACTCLR]) begin
      r_next.actTmr = 32'h0;
    end
    if (wrWdClr && regWdata[rsws_pkg::WD_CLEAR]) begin
      r_next.wdCnt = 16'h0000;
    end

    case (r_reg.state)
      rsws_pkg::ST_COLD: begin
        // Hold resets, then release the core into run
        if (r_reg.cnt >= 32'(rsws_pkg::RST_HOLD_CYC - 1)) begin
          r_next.state  = rsws_pkg::ST_RUN;
          r_next.actTmr = 32'h0;
          r_next.wdCnt  = 16'h0000;
        end
      end
      rsws_pkg::ST_RUN: begin
        if (powerSwitch && !r_reg.pwrPrev) begin
          setFlags[rsws_pkg::ST_PWRSWINT] = 1'b1;
        end
        if (swEvent) begin
          r_next.state = rsws_pkg::ST_RSW;
          setFlags[rsws_pkg::ST_SWITCH] = 1'b1;
          r_next.scopePeri = !r_reg.status[rsws_pkg::ST_RETAIN];
          r_next.scopeGio = 1'b0;
          // Memory controller kept alive, when SDRAM or retention set, to finish and refresh
          r_next.scopeMem = !r_reg.status[rsws_pkg::ST_RETAIN] &&
                            !r_reg.status[rsws_pkg::ST_SDRAM];
        end else if (actExpire) begin
          r_next.state = rsws_pkg::ST_COLD;
          r_next.cnt = 32'h0;
          setFlags[rsws_pkg::ST_TIMEOUT] = 1'b1;
          r_next.scopePeri = 1'b1;
          r_next.scopeGio = 1'b1;
          r_next.scopeMem = 1'b1;
        end else if (wdExpire) begin
          r_next.state = rsws_pkg::ST_COLD;
          r_next.cnt = 32'h0;
          setFlags[rsws_pkg::ST_WATCHDOG] = 1'b1;
          r_next.scopePeri = 1'b1;
          r_next.scopeGio = 1'b0;
          r_next.scopeMem = 1'b1;
        end else if (hibernateReq && !irqPending) begin
          r_next.state = rsws_pkg::ST_HIB;
          r_next.scopePeri = 1'b1;
          r_next.scopeGio = 1'b0;
          r_next.scopeMem = 1'b1;
        end
      end
      rsws_pkg::ST_RSW: begin
        // Core stays in reset while the switch is held
        if (resetSwitchN) begin
          r_next.state = rsws_pkg::ST_COLD;
          r_next.cnt = 32'h0;
        end
      end
      rsws_pkg::ST_HIB: begin
        // Power drops only once the stopped clock has taken hold
        if (r_reg.clkStop && pipelineHalted) begin
          r_next.state = rsws_pkg::ST_SHUT;
        end
      end
      rsws_pkg::ST_SHUT: begin
        if (wake) begin
          r_next.state = rsws_pkg::ST_PON;
          r_next.cnt = 32'h0;
        end
      end
      rsws_pkg::ST_PON: begin
        // Wait measured in ticks; other wakes ignored meanwhile
        if (tickEv) begin
          r_next.cnt = r_reg.cnt + 32'h1;
        end else begin
          r_next.cnt = r_reg.cnt;
        end
        if (r_reg.cnt >= {16'h0000, r_reg.waitTicks}) begin
          r_next.state = rsws_pkg::ST_CHECK;
        end
      end
      rsws_pkg::ST_CHECK: begin
        // Battery sampled with the indicator still up
        if (batteryInhibit) begin
          r_next.state = rsws_pkg::ST_COLD;
          r_next.cnt = 32'h0;
          r_next.scopePeri = 1'b1;
          r_next.scopeGio = 1'b0;
          r_next.scopeMem = 1'b1;
        end else begin
          r_next.state = rsws_pkg::ST_SHUT;
          setFlags[rsws_pkg::ST_BATTERY] = 1'b1;
        end
      end
      default: begin
        r_next.state = rsws_pkg::ST_COLD;
        r_next.cnt = 32'h0;
      end
    endcase

    // Writes of zero clear flags; a same-cycle set wins
    if (wrStatus) begin
      clrFlags = ~regWdata[7:0] & rsws_pkg::ST_FLAGS;
      r_next.status[rsws_pkg::ST_RETAIN] = regWdata[rsws_pkg::ST_RETAIN];
      r_next.status[rsws_pkg::ST_SDRAM]  = regWdata[rsws_pkg::ST_SDRAM];
    end
    r_next.status[5:0] = (r_reg.status[5:0] & ~clrFlags[5:0]) |
                         setFlags[5:0];
    if (wrControl) begin
      r_next.edoMode = regWdata[rsws_pkg::CT_EDO];
    end
    if (wrWait) begin
      r_next.waitTicks = regWdata[15:0];
    end
    if (wrWdCfg) begin
      r_next.wdEn = regWdata[rsws_pkg::WD_ENABLE];
      r_next.wdPeriod = regWdata[rsws_pkg::WD_PER_LSB +: 16];
      r_next.wdCnt = 16'h0000;
    end

    // Registered outputs follow the next state
    r_next.coreRstN = (r_next.state == rsws_pkg::ST_RUN) ||
                      (r_next.state == rsws_pkg::ST_HIB);
    r_next.periRstN = !(r_next.scopePeri &&
                        (r_next.state != rsws_pkg::ST_RUN));
    r_next.gioRstN  = !(r_next.scopeGio &&
                        (r_next.state == rsws_pkg::ST_COLD));
    r_next.memRstN  = !(r_next.scopeMem &&
                        (r_next.state != rsws_pkg::ST_RUN));
    r_next.clkStop  = (r_next.state == rsws_pkg::ST_HIB) ||
                      (r_next.state == rsws_pkg::ST_SHUT);
    r_next.mainPwr  = (r_next.state == rsws_pkg::ST_COLD) ||
                      (r_next.state == rsws_pkg::ST_RUN) ||
                      (r_next.state == rsws_pkg::ST_RSW) ||
                      (r_next.state == rsws_pkg::ST_HIB);
    r_next.ponInd   = (r_next.state == rsws_pkg::ST_PON) ||
                      (r_next.state == rsws_pkg::ST_CHECK);
    // CAS leads RAS by one cycle; no burst refresh around it
    r_next.casN = !((r_next.state == rsws_pkg::ST_RSW) &&
                    r_next.edoMode);
    r_next.rasN = !((r_next.state == rsws_pkg::ST_RSW) && r_next.edoMode &&
                    (r_reg.state == rsws_pkg::ST_RSW));

    // Read data valid the cycle after the strobe only
    r_next.rdata = 32'h0;
    if (regRd && regAddr == rsws_pkg::OFS_STATUS) begin
      r_next.rdata = {24'h0, r_reg.status};
    end else if (regRd && regAddr == rsws_pkg::OFS_CONTROL) begin
      r_next.rdata = {31'h0, r_reg.edoMode};
    end else if (regRd && regAddr == rsws_pkg::OFS_WAIT) begin
      r_next.rdata = {16'h0, r_reg.waitTicks};
    end else if (regRd && regAddr == rsws_pkg::OFS_WDCONFIG) begin
      r_next.rdata = {r_reg.wdPeriod, 15'h0, r_reg.wdEn};
    end
  end

  // Domain reset puts every reset output into reset and the cause flag up
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r_reg <= '{
        state:     rsws_pkg::ST_COLD,
        status:    rsws_pkg::ST_RESET,
        waitTicks: rsws_pkg::PON_DEFAULT_TICKS,
        wdPeriod:  rsws_pkg::WD_PER_RESET,
        swPrev:    1'b1,
        scopePeri: 1'b1,
        scopeGio:  1'b1,
        scopeMem:  1'b1,
        casN:      1'b1,
        rasN:      1'b1,
        default:   '0
      };
    end else begin
      r_reg <= r_next;
    end
  end

  // Port drive
  assign regRdata         = r_reg.rdata;
  assign coreResetN       = r_reg.coreRstN;
  assign periphResetN     = r_reg.periRstN;
  assign gioResetN        = r_reg.gioRstN;
  assign rtcResetN        = r_reg.rtcRstN;
  assign memCtlResetN     = r_reg.memRstN;
  assign coreClockStop    = r_reg.clkStop;
  assign mainPowerEnable  = r_reg.mainPwr;
  assign powerOnIndicator = r_reg.ponInd;
  assign dramCasN         = r_reg.casN;
  assign dramRasN         = r_reg.rasN;

  // Checks on the sequencing
  a_switch_flag_set: assert property (
    @(posedge clk) disable iff (!rstn)
    (r_reg.state == rsws_pkg::ST_RUN && swEvent)
      |=> r_reg.status[rsws_pkg::ST_SWITCH] && !coreResetN)
    else $error("switch event did not flag and reset core");

  a_retain_keeps_peri: assert property (
    @(posedge clk) disable iff (!rstn)
    (r_reg.state == rsws_pkg::ST_RUN && swEvent &&
     r_reg.status[rsws_pkg::ST_RETAIN]) |=> periphResetN && memCtlResetN)
    else $error("retention set but peripherals reset");

  a_sdram_mem_reset: assert property (
    @(posedge clk) disable iff (!rstn)
    (r_reg.state == rsws_pkg::ST_RUN && swEvent &&
     r_reg.status[7:6] == 2'b00) |=> !memCtlResetN && !periphResetN)
    else $error("memory controller not reset on switch");

  a_edo_cas_ras: assert property (
    @(posedge clk) disable iff (!rstn)
    $fell(dramCasN) |-> dramRasN ##1 (!dramRasN || dramCasN))
    else $error("self-refresh strobes out of order");

  a_power_after_halt: assert property (
    @(posedge clk) disable iff (!rstn)
    $fell(mainPowerEnable) |-> $past(coreClockStop) && $past(pipelineHalted))
    else $error("main power dropped before halt");

  a_indicator_unpowered: assert property (
    @(posedge clk) disable iff (!rstn)
    $fell(powerOnIndicator) |-> $past(r_reg.state == rsws_pkg::ST_CHECK))
    else $error("indicator dropped without battery sample");

  a_battery_low_flag: assert property (
    @(posedge clk) disable iff (!rstn)
    (r_reg.state == rsws_pkg::ST_CHECK && !batteryInhibit)
      |=> r_reg.status[rsws_pkg::ST_BATTERY] && !mainPowerEnable
          && !coreResetN)
    else $error("battery low did not abort activation");

  a_battery_ok_boot: assert property (
    @(posedge clk) disable iff (!rstn)
    (r_reg.state == rsws_pkg::ST_CHECK && batteryInhibit)
      |=> mainPowerEnable ##10 coreResetN && periphResetN)
    else $error("activation did not release resets");

  a_wake_no_int: assert property (
    @(posedge clk) disable iff (!rstn)
    $rose(r_reg.status[rsws_pkg::ST_PWRSWINT])
      |-> $past(r_reg.state == rsws_pkg::ST_RUN))
    else $error("wake set the switch interrupt flag");

endmodule
`default_nettype wire

/* File: tb/rsws_core_model.sv */
// Core-side model: hibernate request and pipeline drain
`default_nettype none
module rsws_core_model #(
  parameter int HALT_DLY = 8
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // Bench command and design feedback
  input  wire logic hibCmd,
  input  wire logic coreClockStop,
  // Core outputs
  output logic      hibernateReq,
  output logic      pipelineHalted
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;

  // Pipeline halts some cycles after clock stop, never at once
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 0;
      hibernateReq <= 1'h0;
      pipelineHalted <= 1'h0;
    end else begin
      hibernateReq <= hibCmd;
      cnt <= coreClockStop ? cnt + 1 : 0;
      pipelineHalted <= coreClockStop && cnt >= HALT_DLY;
    end
  end
endmodule
`default_nettype wire

/* File: tb/reset_shutdown_wake_sequencer_tb.sv */
// Bench for the reset, shutdown and wake sequencer
`default_nettype none
module reset_shutdown_wake_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int ACT = 10000;
  localparam int TK = rsws_pkg::TICK_CYC;
  localparam logic [7:0] STA = rsws_pkg::OFS_STATUS;
  localparam logic [7:0] CTL = rsws_pkg::OFS_CONTROL;
  localparam logic [7:0] WDC = rsws_pkg::OFS_WDCONFIG;
  logic        clk, rstn, regWr, regRd, hibCmd, hibernateReq;
  logic        irqPending, pipelineHalted, resetSwitchN, powerSwitch;
  logic        carrierDetectN, cardBusyWakeN, alarmWake, batteryInhibit;
  logic        coreResetN, periphResetN, gioResetN, rtcResetN;
  logic        memCtlResetN, coreClockStop, mainPowerEnable;
  logic        powerOnIndicator, dramCasN, dramRasN;
  logic [7:0]  regAddr;
  logic [15:0] gpioWake;
  logic [31:0] regWdata, regRdata;
  int          mismatches, cmp_count, cyc;

  rsws_sequencer #(.ACT_TIMEOUT(ACT)) DUT (
    .clk, .rstn, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .hibernateReq, .irqPending, .pipelineHalted, .resetSwitchN,
    .powerSwitch, .gpioWake, .carrierDetectN, .cardBusyWakeN,
    .alarmWake, .batteryInhibit, .coreResetN, .periphResetN,
    .gioResetN, .rtcResetN, .memCtlResetN, .coreClockStop,
    .mainPowerEnable, .powerOnIndicator, .dramCasN, .dramRasN
  );

  rsws_core_model core (
    .clk, .rstn, .hibCmd, .coreClockStop, .hibernateReq, .pipelineHalted
  );

  // Free-running 100 MHz clock
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // Hang guard, well above the longest expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 95000) begin
      mismatches++;
      $display("unexpected at %0t: run did not finish", $time);
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (mismatches == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(logic [31:0] got, logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask

  // Ends mid-cycle so outputs of the last edge have landed
  task automatic cyc_wait(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    regWr <= 1'h1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'h0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(logic [7:0] a, logic [31:0] e, logic [31:0] m);
    @(posedge clk);
    regRd <= 1'h1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'h0;
    #1;
    chk(regRdata & m, e);
  endtask

  function automatic logic sig(int s);
    case (s)
      0: return coreResetN;
      1: return powerOnIndicator;
      2: return coreClockStop;
      default: return mainPowerEnable;
    endcase
  endfunction

  // Bounded wait for one output to reach a level
  task automatic waitv(int s, logic v, int n);
    #1;
    for (int i = 0; i < n && sig(s) !== v; i++) cyc_wait(1);
    chk(sig(s), v);
  endtask

  task automatic hib(logic irq);
    @(posedge clk);
    irqPending <= irq;
    hibCmd <= 1'h1;
    @(posedge clk);
    hibCmd <= 1'h0;
  endtask

  task automatic sw(logic ret, logic sd);
    wr(STA, {24'h0, sd, ret, 6'h0});
    @(posedge clk);
    resetSwitchN <= 1'h0;
    waitv(0, 1'h0, 4);
    chk(periphResetN, ret);
    chk(memCtlResetN, ret | sd);
    chk({gioResetN, rtcResetN}, 2'h3);
    cyc_wait(3);
    chk({dramCasN, dramRasN}, 2'h0);
    @(posedge clk);
    resetSwitchN <= 1'h1;
    waitv(0, 1'h1, 15);
    chk({dramCasN, dramRasN}, 2'h3);
    rd(STA, 32'h2, 32'h2);
  endtask

  // Shut down when powered, then wake from one source
  task automatic wake(int src, logic bat);
    if (mainPowerEnable === 1'h1) begin
      hib(1'h0);
      waitv(2, 1'h1, 10);
      chk({periphResetN, mainPowerEnable}, 2'h1);
      waitv(3, 1'h0, 20);
    end
    @(posedge clk);
    batteryInhibit <= bat;
    case (src)
      0: powerSwitch <= 1'h1;
      1: gpioWake <= 16'h8000;
      2: carrierDetectN <= 1'h0;
      3: cardBusyWakeN <= 1'h0;
      default: alarmWake <= 1'h1;
    endcase
    waitv(1, 1'h1, 5);
    @(posedge clk);
    powerSwitch <= 1'h0;
    gpioWake <= 16'h0;
    carrierDetectN <= 1'h1;
    cardBusyWakeN <= 1'h1;
    alarmWake <= 1'h0;
    cyc_wait(TK);
    chk(powerOnIndicator, 1'h1);
    waitv(1, 1'h0, 3 * TK);
    chk(mainPowerEnable, bat);
    if (bat) begin
      waitv(0, 1'h1, 20);
      wr(CTL, 32'h5);
    end else
      chk(coreResetN, 1'h0);
  endtask

  // Main sequence
  initial begin
    {rstn, regWr, regRd, hibCmd, irqPending, powerSwitch} = 6'h0;
    {alarmWake, regAddr, regWdata, gpioWake} = 57'h0;
    {resetSwitchN, carrierDetectN, cardBusyWakeN} = 3'h7;
    batteryInhibit = 1'h1;
    cyc_wait(1);
    chk({coreResetN, periphResetN, gioResetN, rtcResetN}, 4'h0);
    @(posedge clk);
    rstn <= 1'h1;
    waitv(0, 1'h1, 15);
    chk({periphResetN, gioResetN, rtcResetN, memCtlResetN}, 4'hf);
    rd(STA, 32'h1, 32'h3f);
    rd(rsws_pkg::OFS_WAIT, 32'h2af8, 32'hffff);
    rd(8'hfc, 32'h0, 32'hffffffff);
    // Two ticks: the free-running tick makes the first one short
    wr(rsws_pkg::OFS_WAIT, 32'h2);
    wr(CTL, 32'h5);
    for (int i = 0; i < 3; i++) sw(i == 2, i > 0);
    wr(STA, 32'h0);
    wr(CTL, 32'h5);
    // Watchdog: one clear in time, then left to expire
    wr(WDC, 32'h0002_0001);
    cyc_wait(2000);
    wr(rsws_pkg::OFS_WDCLEAR, 32'h1);
    cyc_wait(3000);
    chk(coreResetN, 1'h1);
    waitv(0, 1'h0, 4000);
    chk({periphResetN, gioResetN}, 2'h1);
    waitv(0, 1'h1, 20);
    wr(WDC, 32'h0400_0000);
    rd(STA, 32'h4, 32'h4);
    wr(CTL, 32'h5);
    cyc_wait(ACT - 60);
    chk(coreResetN, 1'h1);
    waitv(0, 1'h0, 100);
    chk({gioResetN, periphResetN, rtcResetN}, 3'h1);
    waitv(0, 1'h1, 20);
    rd(STA, 32'h8, 32'h8);
    // Switch press while running does raise its interrupt flag
    @(posedge clk);
    powerSwitch <= 1'h1;
    @(posedge clk);
    powerSwitch <= 1'h0;
    rd(STA, 32'h20, 32'h20);
    wr(STA, 32'h0);
    wr(CTL, 32'h5);
    hib(1'h1);
    cyc_wait(10);
    chk(coreClockStop, 1'h0);
    wake(0, 1'h1);
    rd(STA, 32'h0, 32'h20);
    wake(3, 1'h0);
    wake(1, 1'h1);
    rd(STA, 32'h10, 32'h10);
    wr(STA, 32'h0);
    rd(STA, 32'h0, 32'h3f);
    wake(2, 1'h1);
    wake(4, 1'h1);
    // Domain reset in mid-run brings the defaults back
    @(posedge clk);
    rstn <= 1'h0;
    @(posedge clk);
    #1;
    chk({coreResetN, rtcResetN, mainPowerEnable}, 3'h0);
    @(posedge clk);
    rstn <= 1'h1;
    waitv(0, 1'h1, 15);
    rd(STA, 32'h1, 32'h3f);
    rd(rsws_pkg::OFS_WAIT, 32'h2af8, 32'hffff);
    report_and_stop();
  end
endmodule
`default_nettype wire
